// File: common/psd_pkg.sv
// Purpose: constants, field layouts and types for the synthesizer control block
// Assumes: clk_sys at 50 MHz, serial write words shifted least significant bit first
// Notes: frame = 4-bit mode code, then 24 data bits in, or 23 readback bits out
//
// Overview of operation
// - sensitivity bit zero selects degraded intermediate input
// - reset clears factory check bits without writes
// - port readback bits follow actual port pin levels
// - readback values captured on entering read mode
// - lock flag zero unlocked, one locked/stopped
// - twenty count bits, most significant first
// - shift clock may idle high or low
// - band bit one: high band, prescaler halves
// - swallow mode divides low band by value
// - direct mode divides low band, 4..4095
// - reference bits choose comparison frequency
// - shifted bits take effect at chip-enable fall
// - count enable zero clears; rising starts measurement
package psd_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ = 50;
    localparam int MS_TIME_US = 1000;
    localparam int MS_CYCLES_DEF = MS_TIME_US * CLK_MHZ;

    // ****************************************************************
    // serial frame
    // ****************************************************************
    localparam int MODE_BITS = 4;
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam int READ_BITS = 23;
    localparam int COUNT_BITS = 20;
    localparam logic [3:0] MODE_WRITE_FIRST = 4'h1;
    localparam logic [3:0] MODE_WRITE_SECOND = 4'h2;
    localparam logic [3:0] MODE_READ = 4'h3;
    localparam logic [23:0] FIRST_RESET = 24'h000000;
    localparam logic [23:0] SECOND_RESET = 24'h000100;

    // ****************************************************************
    // register port
    // ****************************************************************
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK = 4'h1;
    localparam logic [3:0] REG_DIVISOR = 4'h2;
    localparam logic [3:0] REG_COUNT = 4'h3;
    localparam int ST_LATCHED = 0;
    localparam int ST_READBACK = 1;
    localparam int ST_MEASURED = 2;
    localparam int STATUS_BITS = 3;

    // ****************************************************************
    // reference and gate codes
    // ****************************************************************
    localparam logic [3:0] REF_CODE_25K = 4'h3;
    localparam logic [3:0] REF_CODE_5K = 4'hA;
    localparam logic [3:0] REF_CODE_10K = 4'h8;
    localparam logic [6:0] GATE_MS_4 = 7'h04;
    localparam logic [6:0] GATE_MS_8 = 7'h08;
    localparam logic [6:0] GATE_MS_32 = 7'h20;
    localparam logic [6:0] GATE_MS_64 = 7'h40;

    typedef enum logic [1:0] {PSD_REF_OTHER, PSD_REF_25K, PSD_REF_5K, PSD_REF_10K} psd_ref_type;

    typedef struct packed {
        logic [3:0] reference_select_bits;
        logic spare;
        logic count_enable_bit;
        logic band_input_select_bit;
        logic swallow_select_bit;
        logic [15:0] divisor_bits;
    } psd_first_word_type;

    typedef struct packed {
        logic [11:0] spare;
        logic [2:0] factory_check_bits;
        logic intermediate_sensitivity_bit;
        logic unlock_width_sel_high;
        logic unlock_width_sel_low;
        logic gate_time_high;
        logic gate_time_low;
        logic port_out_second;
        logic port_out_first;
        logic port_direction_second;
        logic port_direction_first;
    } psd_second_word_type;

endpackage : psd_pkg

// File: verilog/psd_top.sv
// Purpose: serial control, readback, programmable divider and count of the synthesizer
// Assumes: all pins asynchronous to clk_sys; unlock_detect_in is on clk_sys
// Notes: pin edges are found by sampling, so the shift clock must stay well below clk_sys
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module psd_top
    import psd_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic chip_enable_pin,
    input wire logic shift_tick_pin,
    input wire logic serial_input_pin,
    output logic serial_out_o,
    output logic serial_out_oe,
    input wire logic bidir_port_pin_first_i,
    output logic bidir_port_pin_first_o,
    output logic bidir_port_pin_first_oe,
    input wire logic bidir_port_pin_second_i,
    output logic bidir_port_pin_second_o,
    output logic bidir_port_pin_second_oe,
    input wire logic high_band_input,
    input wire logic low_band_input,
    input wire logic if_input,
    input wire logic unlock_detect_in,
    output logic divided_pulse_o,
    output logic band_select_o,
    output logic sensitivity_normal_o,
    output logic [2:0] factory_check_o,
    output psd_ref_type ref_sel_o,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq_o
);

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    localparam int IN_CE = 7;
    localparam int IN_CL = 6;
    localparam int IN_DI = 5;
    localparam int IN_P1 = 4;
    localparam int IN_P2 = 3;
    localparam int IN_HB = 2;
    localparam int IN_LB = 1;
    localparam int IN_IF = 0;

    logic [7:0] pins_raw;
    logic [7:0] meta_ff;
    logic [7:0] sync_ff;
    logic [7:0] prev_ff;

    assign pins_raw = {chip_enable_pin, shift_tick_pin, serial_input_pin,
                       bidir_port_pin_first_i, bidir_port_pin_second_i,
                       high_band_input, low_band_input, if_input};

    // two flops per pin, then a third stage only for edge finding
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_ff <= 8'h00;
            sync_ff <= 8'h00;
            prev_ff <= 8'h00;
        end else begin
            meta_ff <= pins_raw;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    logic ce_high;
    logic ce_rise;
    logic ce_fall;
    logic cl_rise;
    logic hb_edge;
    logic lb_edge;
    logic if_edge;
    assign ce_high = sync_ff[IN_CE];
    assign ce_rise = sync_ff[IN_CE] & ~prev_ff[IN_CE];
    assign ce_fall = ~sync_ff[IN_CE] & prev_ff[IN_CE];
    // only rising shift edges inside the frame count, so the idle level is irrelevant
    assign cl_rise = ce_high & sync_ff[IN_CL] & ~prev_ff[IN_CL];
    assign hb_edge = sync_ff[IN_HB] & ~prev_ff[IN_HB];
    assign lb_edge = sync_ff[IN_LB] & ~prev_ff[IN_LB];
    assign if_edge = sync_ff[IN_IF] & ~prev_ff[IN_IF];

    // ****************************************************************
    // serial frame engine
    // ****************************************************************
    typedef enum logic [2:0] {SER_IDLE, SER_MODE, SER_WRITE, SER_READ, SER_SKIP} psd_ser_type;

    psd_ser_type ser_state_ff;
    logic [4:0] bit_cnt_ff;
    logic [3:0] mode_sh_ff;
    logic [3:0] mode_ff;
    logic [23:0] shift_ff;
    logic [3:0] nxt_mode;
    logic capture;
    logic latch_w1;
    logic latch_w2;

    assign nxt_mode = {sync_ff[IN_DI], mode_sh_ff[3:1]};
    assign capture = cl_rise && ser_state_ff == SER_MODE
                     && bit_cnt_ff == 5'(MODE_BITS - 1) && nxt_mode == MODE_READ;
    // a frame counts only when exactly a full word arrived
    assign latch_w1 = ce_fall && ser_state_ff == SER_WRITE && bit_cnt_ff == FRAME_BITS
                      && mode_ff == MODE_WRITE_FIRST;
    assign latch_w2 = ce_fall && ser_state_ff == SER_WRITE && bit_cnt_ff == FRAME_BITS
                      && mode_ff == MODE_WRITE_SECOND;

    // mode decode, data shift and bit counting
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ser_state_ff <= SER_IDLE;
            bit_cnt_ff <= 5'h00;
            mode_sh_ff <= 4'h0;
            mode_ff <= 4'h0;
            shift_ff <= 24'h000000;
        end else if (ce_fall) begin
            ser_state_ff <= SER_IDLE;
        end else if (ce_rise) begin
            ser_state_ff <= SER_MODE;
            bit_cnt_ff <= 5'h00;
        end else if (cl_rise) begin
            unique case (ser_state_ff)
                SER_MODE: begin
                    mode_sh_ff <= nxt_mode;
                    bit_cnt_ff <= bit_cnt_ff + 5'h01;
                    if (bit_cnt_ff == 5'(MODE_BITS - 1)) begin
                        mode_ff <= nxt_mode;
                        bit_cnt_ff <= 5'h00;
                        if (nxt_mode == MODE_WRITE_FIRST || nxt_mode == MODE_WRITE_SECOND) begin
                            ser_state_ff <= SER_WRITE;
                        end else if (nxt_mode == MODE_READ) begin
                            ser_state_ff <= SER_READ;
                        end else begin
                            ser_state_ff <= SER_SKIP;
                        end
                    end
                end
                SER_WRITE: begin
                    shift_ff <= {sync_ff[IN_DI], shift_ff[23:1]};
                    if (bit_cnt_ff != 5'h1F) begin
                        bit_cnt_ff <= bit_cnt_ff + 5'h01; // saturates: long frames are dropped
                    end
                end
                SER_IDLE, SER_READ, SER_SKIP: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // control words
    // ****************************************************************
    psd_first_word_type word1_ff;
    psd_second_word_type word2_ff;

    // first word: divisor, band, swallow, count enable, reference
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            word1_ff <= psd_first_word_type'(FIRST_RESET);
        end else if (latch_w1) begin
            word1_ff <= psd_first_word_type'(shift_ff);
        end
    end

    // second word; reset value leaves the check bits clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            word2_ff <= psd_second_word_type'(SECOND_RESET);
        end else if (latch_w2) begin
            word2_ff <= psd_second_word_type'(shift_ff);
        end
    end

    assign sensitivity_normal_o = word2_ff.intermediate_sensitivity_bit;
    assign factory_check_o = word2_ff.factory_check_bits;
    assign band_select_o = word1_ff.band_input_select_bit;
    assign bidir_port_pin_first_o = word2_ff.port_out_first;
    assign bidir_port_pin_first_oe = word2_ff.port_direction_first;
    assign bidir_port_pin_second_o = word2_ff.port_out_second;
    assign bidir_port_pin_second_oe = word2_ff.port_direction_second;

    // ****************************************************************
    // reference select decode
    // ****************************************************************
    function automatic psd_ref_type ref_decode(input logic [3:0] code);
        ref_decode = PSD_REF_OTHER;
        if (code == REF_CODE_25K) ref_decode = PSD_REF_25K;
        if (code == REF_CODE_5K) ref_decode = PSD_REF_5K;
        if (code == REF_CODE_10K) ref_decode = PSD_REF_10K;
    endfunction : ref_decode

    psd_ref_type ref_sel_ff;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ref_sel_ff <= PSD_REF_OTHER;
        end else begin
            ref_sel_ff <= ref_decode(word1_ff.reference_select_bits);
        end
    end
    assign ref_sel_o = ref_sel_ff;

    // ****************************************************************
    // programmable divider
    // ****************************************************************
    // count loaded per input event; direct mode drops the four low divisor bits
    function automatic logic [15:0] set_count(input psd_first_word_type w);
        if (w.band_input_select_bit || w.swallow_select_bit) begin
            set_count = w.divisor_bits;
        end else begin
            set_count = {4'h0, w.divisor_bits[15:4]};
        end
    endfunction : set_count

    logic prescale_ff;
    logic [15:0] div_cnt_ff;
    logic div_pulse_ff;
    logic div_event;
    logic [15:0] div_set;

    assign div_set = set_count(word1_ff);
    // high band passes the halving prescaler, swallow bit ignored there
    assign div_event = word1_ff.band_input_select_bit ? (hb_edge & prescale_ff) : lb_edge;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prescale_ff <= 1'b0;
        end else if (hb_edge) begin
            prescale_ff <= ~prescale_ff;
        end
    end

    // down counter; cleared on a new first word so a changed divisor acts at the next event
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_cnt_ff <= 16'h0000;
            div_pulse_ff <= 1'b0;
        end else begin
            div_pulse_ff <= 1'b0;
            if (latch_w1) begin
                div_cnt_ff <= 16'h0000;
            end else if (div_event) begin
                if (div_cnt_ff == 16'h0000) begin
                    div_cnt_ff <= div_set - 16'h0001;
                    div_pulse_ff <= 1'b1;
                end else begin
                    div_cnt_ff <= div_cnt_ff - 16'h0001;
                end
            end
        end
    end
    assign divided_pulse_o = div_pulse_ff;

    // ****************************************************************
    // intermediate frequency counter
    // ****************************************************************
    typedef enum logic [1:0] {MEAS_IDLE, MEAS_GATE, MEAS_DONE} psd_meas_type;

    function automatic logic [6:0] gate_ms(input logic hi, input logic lo);
        unique case ({hi, lo})
            2'b00: gate_ms = GATE_MS_4;
            2'b01: gate_ms = GATE_MS_8;
            2'b10: gate_ms = GATE_MS_32;
            2'b11: gate_ms = GATE_MS_64;
        endcase
    endfunction : gate_ms

    psd_meas_type meas_state_ff;
    logic [21:0] gate_timer_ff;
    logic [COUNT_BITS-1:0] if_count_ff;
    logic [21:0] gate_len;
    logic cte_rise;
    logic cte_clear;
    logic meas_done;

    assign gate_len = 22'(gate_ms(word2_ff.gate_time_high, word2_ff.gate_time_low)) * 22'(MS_CYCLES);
    psd_first_word_type shift_word;
    assign shift_word = psd_first_word_type'(shift_ff);
    assign cte_rise = latch_w1 && shift_word.count_enable_bit && !word1_ff.count_enable_bit;
    assign cte_clear = latch_w1 && !shift_word.count_enable_bit;
    assign meas_done = meas_state_ff == MEAS_GATE && gate_timer_ff == gate_len - 22'h000001;

    // gate runs once per enable rise; the count saturates rather than wraps
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meas_state_ff <= MEAS_IDLE;
            gate_timer_ff <= 22'h000000;
            if_count_ff <= '0;
        end else if (cte_clear) begin
            meas_state_ff <= MEAS_IDLE;
            gate_timer_ff <= 22'h000000;
            if_count_ff <= '0;
        end else if (cte_rise) begin
            meas_state_ff <= MEAS_GATE;
            gate_timer_ff <= 22'h000000;
            if_count_ff <= '0;
        end else if (meas_state_ff == MEAS_GATE) begin
            gate_timer_ff <= gate_timer_ff + 22'h000001;
            if (if_edge && if_count_ff != {COUNT_BITS{1'b1}}) begin
                if_count_ff <= if_count_ff + 20'h00001;
            end
            if (meas_done) begin
                meas_state_ff <= MEAS_DONE;
            end
        end
    end

    // ****************************************************************
    // readback word
    // ****************************************************************
    logic [READ_BITS-1:0] rb_sh_ff;
    logic lock_now;
    logic dout_oe_ff;

    // stopped detection reads as locked
    assign lock_now = ~(word2_ff.unlock_width_sel_high | word2_ff.unlock_width_sel_low)
                      | ~unlock_detect_in;

    // snapshot on entering read mode, then shift out one bit per rising edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rb_sh_ff <= '0;
        end else if (capture) begin
            rb_sh_ff <= {sync_ff[IN_P1], sync_ff[IN_P2], lock_now, if_count_ff};
        end else if (cl_rise && ser_state_ff == SER_READ) begin
            rb_sh_ff <= {rb_sh_ff[READ_BITS-2:0], 1'b0};
        end
    end

    // open drain: pull low only for a zero bit inside a read frame
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dout_oe_ff <= 1'b0;
        end else begin
            dout_oe_ff <= ce_high && ser_state_ff == SER_READ && !rb_sh_ff[READ_BITS-1];
        end
    end
    assign serial_out_oe = dout_oe_ff;
    assign serial_out_o = rb_sh_ff[READ_BITS-1];

    // ****************************************************************
    // register port and interrupt
    // ****************************************************************
    logic [STATUS_BITS-1:0] status_ff;
    logic [STATUS_BITS-1:0] mask_ff;
    logic [STATUS_BITS-1:0] nxt_status;
    logic [STATUS_BITS-1:0] status_clr;
    logic [STATUS_BITS-1:0] status_set;
    logic [31:0] rdata_ff;
    logic irq_ff;

    assign status_clr = (reg_wr && reg_addr == REG_STATUS) ? reg_wdata[STATUS_BITS-1:0] : '0;
    assign status_set = {meas_done, capture, latch_w1 | latch_w2};
    // set beats a clear arriving in the same cycle
    assign nxt_status = (status_ff & ~status_clr) | status_set;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_ff <= '0;
            mask_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff <= |(status_ff & mask_ff);
            if (reg_wr && reg_addr == REG_MASK) begin
                mask_ff <= reg_wdata[STATUS_BITS-1:0];
            end
        end
    end

    // read data valid the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= 32'h00000000;
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_STATUS: rdata_ff <= 32'(status_ff);
                    REG_MASK: rdata_ff <= 32'(mask_ff);
                    REG_DIVISOR: rdata_ff <= {15'h0000, word1_ff.band_input_select_bit, div_set};
                    REG_COUNT: rdata_ff <= 32'(if_count_ff);
                    default: rdata_ff <= 32'h00000000;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_ff;
    assign irq_o = irq_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_enter_read;
        capture;
    endsequence
    sequence s_read_shift;
        cl_rise && ser_state_ff == SER_READ && !capture;
    endsequence

    a_sens_mode: assert property (latch_w2 |=> sensitivity_normal_o == $past(shift_ff[8]))
        else $error("sensitivity output not taken from latched word");
    a_check_reset: assert property ($past(reset) |-> factory_check_o == 3'h0)
        else $error("check bits not clear after reset");
    a_port_capture: assert property (s_enter_read |=> rb_sh_ff[22] == $past(sync_ff[IN_P1])
        && rb_sh_ff[21] == $past(sync_ff[IN_P2]))
        else $error("port readback not captured from pins");
    a_lock_flag: assert property (s_enter_read |=> rb_sh_ff[20] == $past(~unlock_detect_in
        | ~(word2_ff.unlock_width_sel_high | word2_ff.unlock_width_sel_low)))
        else $error("lock flag wrong");
    a_count_snap: assert property (s_enter_read |=> rb_sh_ff[19:0] == $past(if_count_ff))
        else $error("count not captured at read entry");
    a_msb_order: assert property (s_read_shift |=> rb_sh_ff[22:1] == $past(rb_sh_ff[21:0]))
        else $error("readback not shifted most significant first");
    a_latch_fall: assert property (!$past(latch_w1) |-> $stable(word1_ff))
        else $error("first word changed without chip-enable fall");
    a_count_clear: assert property (!word1_ff.count_enable_bit |-> if_count_ff == 20'h00000)
        else $error("count not held clear while disabled");
    a_prescale: assert property (word1_ff.band_input_select_bit && hb_edge && !prescale_ff
        |-> !div_event ##1 prescale_ff)
        else $error("high band not halved");
    a_direct_div: assert property (!word1_ff.band_input_select_bit && !word1_ff.swallow_select_bit
        && div_event && div_cnt_ff == 16'h0000 && !latch_w1
        |=> div_cnt_ff == {4'h0, $past(word1_ff.divisor_bits[15:4])} - 16'h0001)
        else $error("direct divisor reload wrong");
    a_ref_decode: assert property (word1_ff.reference_select_bits == REF_CODE_5K
        |=> ref_sel_o == PSD_REF_5K)
        else $error("reference decode wrong");
    a_irq_level: assert property (##1 irq_o == $past(|(status_ff & mask_ff)))
        else $error("interrupt level does not follow masked status");

endmodule : psd_top
`default_nettype wire

// File: verification/psd_ctrl.sv
// Purpose: controller model on the serial link
// Assumes: shift clock half period 80 ns
// Notes: idle gives the shift clock level between frames
`timescale 1ns/1ps
`default_nettype none
module psd_ctrl (
    output logic ce,
    output logic cl,
    output logic di,
    input wire logic sd
);
    logic idle = 1'b0;
    logic [22:0] rx;
    initial begin
        ce = 1'b0;
        cl = 1'b0;
        di = 1'b0;
    end
    // mode then data, bit 0 first; sample before the device advances
    task automatic frame(input logic [3:0] m, input logic [23:0] w, input int n);
        logic [27:0] b;
        b = {w, m};
        cl = idle;
        #800;
        ce = 1'b1;
        #800;
        for (int i = 0; i < n + 4; i++) begin
            di = b[i];
            cl = 1'b0;
            #80;
            if (i > 3)
                rx[i - 4] = sd;
            cl = 1'b1;
            #80;
        end
        cl = idle;
        #800;
        ce = 1'b0;
        di = ~di; // no stale level after release
        #1600;
    endtask : frame
endmodule : psd_ctrl
`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench for the synthesizer control block
// Assumes: MS_CYCLES cut to 10
// Notes: divider pulses are counted here; the gated count is read back from REG_COUNT and checked
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import psd_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic p1 = 1'b1;
    logic p2 = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic high_band_input = 1'b0;
    logic low_band_input = 1'b0;
    logic if_input = 1'b0;
    logic unlock_detect_in = 1'b0;
    wire chip_enable_pin, shift_tick_pin, serial_input_pin, serial_out_o, serial_out_oe;
    wire bidir_port_pin_first_o, bidir_port_pin_first_oe, bidir_port_pin_second_o;
    wire bidir_port_pin_second_oe, divided_pulse_o, band_select_o, sensitivity_normal_o;
    wire irq_o;
    wire [2:0] factory_check_o;
    wire [31:0] reg_rdata;
    psd_ref_type ref_sel_o;
    wire bidir_port_pin_first_i = bidir_port_pin_first_oe ? bidir_port_pin_first_o : p1;
    wire bidir_port_pin_second_i = bidir_port_pin_second_oe ? bidir_port_pin_second_o : p2;
    wire sd = serial_out_oe ? 1'b0 : 1'b1; // pull-up on the open-drain line
    logic [3:0] codes [3] = '{REF_CODE_25K, REF_CODE_5K, REF_CODE_10K};
    // high band divisor 2, swallow divisor 4, direct divisor 4 with low bits set
    logic [23:0] div_words [3] = '{24'h020002, 24'h010004, 24'h00004F};
    int pulses = 0;
    int bad_count = 0;
    int comparisons = 0;
    always #10 clk_sys = ~clk_sys;
    // free running intermediate input, a rising edge every 4 cycles
    always begin
        repeat (2) @(posedge clk_sys);
        if_input <= ~if_input;
    end
    always @(posedge clk_sys)
        if (divided_pulse_o === 1'b1)
            pulses <= pulses + 1;
    psd_top #(.MS_CYCLES(10)) uut (.*);
    psd_ctrl ctrl (.ce(chip_enable_pin), .cl(shift_tick_pin), .di(serial_input_pin), .sd(sd));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= ~w;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk_sys);
    endtask : bus
    task automatic settle();
        repeat (8) @(posedge clk_sys);
        #1;
    endtask : settle
    // word latch, sensitivity, interrupt raise, mask and clear
    task automatic t_word();
        chk("factory_check_o", 0, factory_check_o);
        chk("sensitivity_normal_o", 1, sensitivity_normal_o);
        bus(REG_MASK, 32'h1, 1'b1);
        ctrl.frame(MODE_WRITE_SECOND, 24'h000000, 24);
        settle();
        chk("sensitivity_normal_o", 0, sensitivity_normal_o);
        chk("irq_o", 1, irq_o);
        bus(REG_STATUS, 32'h0, 1'b0);
        chk("reg_status", 1, reg_rdata);
        bus(REG_MASK, 32'h0, 1'b0);
        chk("reg_mask", 1, reg_rdata);
        bus(4'hF, 32'h0, 1'b0);
        chk("reg_rdata", 0, reg_rdata);
        bus(REG_STATUS, 32'h7, 1'b1);
        settle();
        chk("irq_o", 0, irq_o);
    endtask : t_word
    // every reference code with the high band picked
    task automatic t_ref();
        for (int i = 0; i < 3; i++) begin
            ctrl.frame(MODE_WRITE_FIRST, {codes[i], 4'h2, 16'h07DE}, 24);
            settle();
            chk("ref_sel_o", 32'(i + 1), 32'(ref_sel_o));
            chk("band_select_o", 1, band_select_o);
        end
    endtask : t_ref
    // readback with the shift clock idling low, then high
    task automatic t_read();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            ctrl.idle = k[0];
            p1 <= ~k[0];
            p2 <= k[0];
            ctrl.frame(MODE_READ, 24'h0, 23);
            chk("readback", {29'h1, p2, p1}, {9'h0, ctrl.rx});
        end
    endtask : t_read
    // each divider mode with divisor 4 in effect: 8 counted edges give 2 pulses
    task automatic t_div();
        for (int m = 0; m < 3; m++) begin
            ctrl.frame(MODE_WRITE_FIRST, div_words[m], 24);
            pulses = 0;
            repeat (16) begin
                @(posedge clk_sys);
                if (m == 0)
                    high_band_input <= ~high_band_input;
                else
                    low_band_input <= ~low_band_input;
                repeat (4) @(posedge clk_sys);
            end
            settle();
            chk("divided_pulses", 2, pulses);
        end
    endtask : t_div
    // one 4 ms gate of 10 cycles per ms, edge every 4 cycles; enable zero clears
    task automatic t_count();
        ctrl.frame(MODE_WRITE_FIRST, 24'h040000, 24);
        settle();
        bus(REG_COUNT, 32'h0, 1'b0);
        chk("reg_count", 32'(GATE_MS_4) * 10 / 4, reg_rdata);
        bus(REG_STATUS, 32'h0, 1'b0);
        chk("status_measured", 1, reg_rdata[ST_MEASURED]);
        ctrl.frame(MODE_WRITE_FIRST, 24'h000000, 24);
        bus(REG_COUNT, 32'h0, 1'b0);
        chk("reg_count", 0, reg_rdata);
    endtask : t_count
    task automatic conclude();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        settle();
        t_word();
        t_ref();
        t_read();
        t_div();
        t_count();
        conclude();
    end
    // eleven link frames of about 8.5 us each need well under 0.4 ms
    initial begin
        #400000;
        bad_count++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
